// File: hdl/timeslot_connection_latency_ctrl.sv
/*
 * Latency control top: global control register over AXI4-Lite, buffer-select
 * resolution and a registered latency result for the presented connection.
 * Assumes connection fields come from logic on the same clock.
 */
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module timeslot_connection_latency_ctrl
    import latency_pkg::*;
(
    input  wire logic                             clock,
    input  wire logic                             resetn,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [11:0]                      s_axi_awaddr,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    output logic [1:0]                            s_axi_bresp,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    input  wire logic [11:0]                      s_axi_araddr,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    input  wire logic                             connValid,
    input  wire logic                             busSwitching,
    input  wire logic [latency_pkg::SLOT_W-1:0]   fromSlot,
    input  wire logic [latency_pkg::SLOT_W-1:0]   toSlot,
    input  wire logic [latency_pkg::STREAM_W-1:0] fromStream,
    input  wire logic [latency_pkg::STREAM_W-1:0] toStream,
    input  wire logic                             localBufferSelect,
    input  wire logic                             tagBufferSelect,
    output logic                                  bufferSelect,
    output logic                                  resultValid,
    output logic                                  resultForward,
    output logic                                  resultReverse,
    output logic [latency_pkg::LAT_W-1:0]         resultLatency,
    output logic signed [latency_pkg::STRD_W-1:0] resultStreamDelta
);
    import latency_pkg::*;

    // ==========================================================
    // Register bus
    logic [7:0]  globalCtrl;
    logic        awHeld;
    logic        wHeld;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        illegalSeen;
    logic [3:0]  lastClass;

    wire logic doWrite    = awHeld && wHeld && !s_axi_bvalid;
    wire logic wrHit      = awAddr == ADDR_GLOBAL_CTRL;
    wire logic wrStatus   = awAddr == ADDR_STATUS;
    wire logic rdHitCtrl  = s_axi_araddr == ADDR_GLOBAL_CTRL;
    wire logic rdHitStat  = s_axi_araddr == ADDR_STATUS;
    wire logic takeRead   = s_axi_arvalid && s_axi_arready;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            awAddr <= '0;
            wData  <= '0;
            wStrb  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            globalCtrl   <= GC_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (doWrite) begin
                if (wrHit && wStrb[0]) begin
                    globalCtrl <= wData[7:0];
                end
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wrHit || wrStatus) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (takeRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= (rdHitCtrl || rdHitStat) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata  <= rdHitCtrl ? {24'h00_0000, globalCtrl} :
                            rdHitStat ? {27'h000_0000, illegalSeen, lastClass} :
                            32'h0000_0000;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Buffer-select resolution
    wire logic globalOverride = globalCtrl[GC_OVERRIDE_BIT];
    wire logic globalValue    = globalCtrl[GC_VALUE_BIT];
    wire logic perConnSelect  = busSwitching ? tagBufferSelect : localBufferSelect;
    wire logic effSelect      = globalOverride ? globalValue : perConnSelect;

    logic signed [STRD_W-1:0]  calcStreamDelta;
    logic                      calcForward;
    logic                      calcReverse;
    logic [LAT_W-1:0]          calcLatency;
    lat_class_t                calcClass;

    latency_calc u_calc (
        .fromSlot     (fromSlot),
        .toSlot       (toSlot),
        .fromStream   (fromStream),
        .toStream     (toStream),
        .bufferSelect (effSelect),
        .slotDelta    (),
        .streamDelta  (calcStreamDelta),
        .isForward    (calcForward),
        .isReverse    (calcReverse),
        .latency      (calcLatency),
        .latClass     (calcClass)
    );

    // ==========================================================
    // Result registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bufferSelect      <= 1'b0;
            resultValid       <= 1'b0;
            resultForward     <= 1'b0;
            resultReverse     <= 1'b0;
            resultLatency     <= '0;
            resultStreamDelta <= '0;
            lastClass         <= '0;
            illegalSeen       <= 1'b0;
        end else begin
            resultValid <= connValid;
            if (connValid) begin
                bufferSelect      <= effSelect;
                resultForward     <= calcForward;
                resultReverse     <= calcReverse;
                resultLatency     <= calcLatency;
                resultStreamDelta <= calcStreamDelta;
                lastClass         <= 4'(1 << calcClass);
            end
            // Sticky flag; a new illegal request wins over the clear
            if (connValid && calcClass == LAT_ILLEGAL) begin
                illegalSeen <= 1'b1;
            end else if (doWrite && wrStatus && wStrb[0] && wData[4]) begin
                illegalSeen <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checks
    property p_override;
        @(posedge clock) disable iff (!resetn)
        connValid && globalOverride |=> bufferSelect == $past(globalValue);
    endproperty
    a_override: assert property (p_override) else $error("override ignored");

    property p_perconn;
        @(posedge clock) disable iff (!resetn)
        connValid && !globalOverride |=> bufferSelect == $past(perConnSelect);
    endproperty
    a_perconn: assert property (p_perconn) else $error("per-connection select wrong");

    property p_forward;
        @(posedge clock) disable iff (!resetn)
        connValid && toSlot > fromSlot |=> resultForward && !resultReverse;
    endproperty
    a_forward: assert property (p_forward) else $error("forward misclassified");

    property p_reverse;
        @(posedge clock) disable iff (!resetn)
        connValid && toSlot < fromSlot |=> resultReverse && !resultForward;
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse misclassified");

    property p_const_fwd;
        @(posedge clock) disable iff (!resetn)
        connValid && effSelect && toSlot >= fromSlot && (toSlot - fromSlot) > 7'd1
        |=> resultLatency == 9'(FRAME_SLOTS + 9'($past(toSlot)) - 9'($past(fromSlot)));
    endproperty
    a_const_fwd: assert property (p_const_fwd) else $error("constant forward latency");

    property p_min_fwd;
        @(posedge clock) disable iff (!resetn)
        connValid && !effSelect && toSlot > fromSlot && (toSlot - fromSlot) > 7'd2
        |=> resultLatency == 9'($past(toSlot)) - 9'($past(fromSlot));
    endproperty
    a_min_fwd: assert property (p_min_fwd) else $error("minimum forward latency");

    property p_wrap_one;
        @(posedge clock) disable iff (!resetn)
        connValid && !effSelect && toSlot == fromSlot + 7'd1 && fromSlot != 7'd127
        |=> resultLatency == LAT_WRAP_ONE;
    endproperty
    a_wrap_one: assert property (p_wrap_one) else $error("delta +1 latency");

    property p_stream;
        @(posedge clock) disable iff (!resetn)
        connValid |=> resultStreamDelta ==
            STRD_W'($signed({1'b0, $past(toStream)}) - $signed({1'b0, $past(fromStream)}));
    endproperty
    a_stream: assert property (p_stream) else $error("stream delta wrong");

    // Forward connection, delta 3 or more, while global bits are 11
    sequence s_mode11_fwd;
        connValid && globalCtrl[1:0] == 2'b11 &&
        toSlot > fromSlot && (toSlot - fromSlot) > 7'd2;
    endsequence
    property p_mode11;
        @(posedge clock) disable iff (!resetn)
        s_mode11_fwd |=> resultLatency ==
            9'(FRAME_SLOTS + 9'($past(toSlot)) - 9'($past(fromSlot)));
    endproperty
    a_mode11: assert property (p_mode11) else $error("global mode 11 latency");
endmodule

// File: hdl/latency_pkg.sv
/*
 * Package for the connection latency controller: register map, field positions,
 * slot figures and latency classes.
 * Assumes an AXI4-Lite slave with 32-bit data; register at 0x0E is indexed (x4).
 */
package latency_pkg;
    localparam int          SLOT_W          = 7;
    localparam int          STREAM_W        = 5;
    localparam int          DELTA_W         = 8;
    localparam int          STRD_W          = 6;
    localparam int          LAT_W           = 9;
    localparam logic [7:0]  IDX_GLOBAL_CTRL = 8'h0E;
    localparam logic [7:0]  IDX_STATUS      = 8'h0F;
    localparam logic [11:0] ADDR_GLOBAL_CTRL = 12'h038;
    localparam logic [11:0] ADDR_STATUS     = 12'h03C;
    localparam int          GC_OVERRIDE_BIT = 1;
    localparam int          GC_VALUE_BIT    = 0;
    localparam logic [7:0]  GC_RESET        = 8'h00;
    localparam logic [8:0]  FRAME_SLOTS     = 9'd128;
    localparam logic [8:0]  TWO_FRAMES      = 9'd256;
    localparam logic [8:0]  LAT_WRAP_ONE    = 9'd257;
    localparam logic [8:0]  LAT_WRAP_TWO    = 9'd258;
    localparam logic [8:0]  LAT_SHORT_TWO   = 9'd2;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    typedef enum logic [1:0] {LAT_MIN, LAT_CONST, LAT_SPECIAL, LAT_ILLEGAL} lat_class_t;
endpackage

// File: hdl/latency_calc.sv
/*
 * Combinational latency evaluator for one connection.
 * Assumes its inputs are stable within a cycle; result registered by caller.
 */
`timescale 1ns/1ps
module latency_calc
    import latency_pkg::*;
(
    input  wire logic [latency_pkg::SLOT_W-1:0]   fromSlot,
    input  wire logic [latency_pkg::SLOT_W-1:0]   toSlot,
    input  wire logic [latency_pkg::STREAM_W-1:0] fromStream,
    input  wire logic [latency_pkg::STREAM_W-1:0] toStream,
    input  wire logic                             bufferSelect,
    output logic signed [latency_pkg::DELTA_W-1:0] slotDelta,
    output logic signed [latency_pkg::STRD_W-1:0] streamDelta,
    output logic                                  isForward,
    output logic                                  isReverse,
    output logic [latency_pkg::LAT_W-1:0]         latency,
    output latency_pkg::lat_class_t               latClass
);
    // Signed slot and stream differences of zero-extended fields
    assign slotDelta   = $signed({1'b0, toSlot}) - $signed({1'b0, fromSlot});
    assign streamDelta = $signed({1'b0, toStream}) - $signed({1'b0, fromStream});
    assign isForward   = slotDelta > 0;
    assign isReverse   = slotDelta < 0;

    wire logic [LAT_W-1:0] deltaExt = LAT_W'(slotDelta);
    wire logic             strNeg   = streamDelta < 0;
    wire logic             nonNeg   = !slotDelta[DELTA_W-1];

    always_comb begin
        latency  = '0;
        latClass = LAT_MIN;
        if (slotDelta == 0 && streamDelta == 0) begin
            latClass = LAT_ILLEGAL;
        end else if ((!bufferSelect && slotDelta == 1) ||
                     (bufferSelect && slotDelta == -127)) begin
            latency  = LAT_WRAP_ONE;
            latClass = LAT_SPECIAL;
        end else if ((!bufferSelect && slotDelta == 2) ||
                     (bufferSelect && slotDelta == -126)) begin
            latency  = strNeg ? LAT_WRAP_TWO : LAT_SHORT_TWO;
            latClass = LAT_SPECIAL;
        end else if (bufferSelect) begin
            latency  = FRAME_SLOTS + deltaExt;
            latClass = nonNeg ? LAT_CONST : LAT_MIN;
        end else begin
            latency  = nonNeg ? deltaExt : TWO_FRAMES + deltaExt;
            latClass = nonNeg ? LAT_MIN : LAT_CONST;
        end
    end
endmodule

// File: verification/conn_source.sv
/*
 * Connection source standing in for the switching memories.
 * Assumes the latency controller samples fields on each rising clock.
 */
`timescale 1ns/1ps
module conn_source
    import latency_pkg::*;
(
    input  wire logic                             clock,
    output logic                                  connValid,
    output logic                                  busSwitching,
    output logic [latency_pkg::SLOT_W-1:0]        fromSlot,
    output logic [latency_pkg::SLOT_W-1:0]        toSlot,
    output logic [latency_pkg::STREAM_W-1:0]      fromStream,
    output logic [latency_pkg::STREAM_W-1:0]      toStream,
    output logic                                  localBufferSelect,
    output logic                                  tagBufferSelect
);
    initial begin
        {connValid, busSwitching, fromSlot, toSlot} = '0;
        {fromStream, toStream, localBufferSelect, tagBufferSelect} = '0;
    end
    // ====
    // One connection, held one cycle
    task automatic present(input int fs, ts, fst, tst, input bit loc, tag, bus);
        if (fs == ts && fst == tst) begin
            return;
        end
        @(posedge clock);
        connValid         <= 1'b1;
        fromSlot          <= 7'(fs);
        toSlot            <= 7'(ts);
        fromStream        <= 5'(fst);
        toStream          <= 5'(tst);
        localBufferSelect <= loc;
        tagBufferSelect   <= tag;
        busSwitching      <= bus;
        @(posedge clock);
        connValid         <= 1'b0;
    endtask
endmodule

// File: verification/tb_top.sv
/*
 * Testbench: control register over AXI4-Lite, then a latency table per mode.
 * Assumes the connection source model and latency_pkg.
 */
`timescale 1ns/1ps
module tb_top;
    import latency_pkg::*;
    logic        clock = 0, resetn = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = '0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic        connValid, busSwitching, localBufferSelect, tagBufferSelect;
    logic [6:0]  fromSlot, toSlot;
    logic [4:0]  fromStream, toStream;
    logic        bufferSelect, resultValid, resultForward, resultReverse;
    logic [8:0]  resultLatency;
    logic signed [5:0] resultStreamDelta;
    logic [31:0] rd;
    int          miscompares = 0, n_checks = 0;
    logic [7:0]  modes [4] = '{8'h00, 8'h01, 8'h02, 8'h03};
    always #50 clock = ~clock;
    timeslot_connection_latency_ctrl i_dut (.clock(clock), .resetn(resetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .connValid(connValid),
        .busSwitching(busSwitching), .fromSlot(fromSlot), .toSlot(toSlot),
        .fromStream(fromStream), .toStream(toStream),
        .localBufferSelect(localBufferSelect), .tagBufferSelect(tagBufferSelect),
        .bufferSelect(bufferSelect), .resultValid(resultValid),
        .resultForward(resultForward), .resultReverse(resultReverse),
        .resultLatency(resultLatency), .resultStreamDelta(resultStreamDelta));
    conn_source i_src (.clock(clock), .connValid(connValid), .busSwitching(busSwitching),
        .fromSlot(fromSlot), .toSlot(toSlot), .fromStream(fromStream),
        .toStream(toStream), .localBufferSelect(localBufferSelect),
        .tagBufferSelect(tagBufferSelect));
    // ====
    // Checking and verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(inout int n);
        @(posedge clock);
        n++;
        if (n > 50) begin
            miscompares++;
            final_report();
        end
    endtask
    // ====
    // AXI4-Lite master
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        bit awDone = 0, wDone = 0;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'h1;
        bready  <= 1'b1;
        while (!(awDone && wDone)) begin
            tick(n);
            if (awvalid && awready === 1'b1) begin
                awDone = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                wDone = 1;
                wvalid <= 1'b0;
            end
        end
        do tick(n); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [11:0] a);
        int n = 0;
        @(posedge clock);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) tick(n);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // ====
    // One connection against the expected latency
    task automatic runCase(input int fs, ts, fst, tst, input bit loc, tag, bus,
                           input logic [7:0] ctrl);
        int d, sd, lat;
        bit sel;
        d = ts - fs;
        sd = tst - fst;
        sel = ctrl[1] ? ctrl[0] : (bus ? tag : loc);
        if ((!sel && d == 1) || (sel && d == -127)) lat = 257;
        else if ((!sel && d == 2) || (sel && d == -126)) lat = (sd < 0) ? 258 : 2;
        else if (sel) lat = 128 + d;
        else lat = (d >= 0) ? d : 256 + d;
        i_src.present(fs, ts, fst, tst, loc, tag, bus);
        @(negedge clock);
        check("valid", {31'h0, resultValid}, 32'h0000_0001);
        check("select", {31'h0, bufferSelect}, {31'h0, sel});
        check("forward", {31'h0, resultForward}, {31'h0, d > 0});
        check("reverse", {31'h0, resultReverse}, {31'h0, d < 0});
        check("latency", {23'h0, resultLatency}, 32'(lat));
        check("sdelta", {26'h0, resultStreamDelta}, {26'h0, 6'(sd)});
    endtask
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        axiRead(ADDR_GLOBAL_CTRL);
        check("ctrl reset", rd, {24'h0, GC_RESET});
        axiWrite(ADDR_GLOBAL_CTRL, 32'h1234_56A7);
        axiRead(ADDR_GLOBAL_CTRL);
        check("ctrl rw", rd, 32'h0000_00A7);
        axiRead(12'h100);
        check("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        check("unmapped rdata", rd, 32'h0000_0000);
        axiWrite(12'h100, 32'h0000_0001);
        check("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        foreach (modes[m]) begin
            axiWrite(ADDR_GLOBAL_CTRL, {24'h0, modes[m]});
            check("ctrl bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
            runCase(0, 127, 0, 0, 0, 1, 0, modes[m]);
            runCase(127, 0, 1, 0, 1, 0, 0, modes[m]);
            runCase(10, 11, 0, 0, 0, 1, 0, modes[m]);
            runCase(10, 12, 3, 1, 0, 0, 0, modes[m]);
            runCase(10, 12, 1, 3, 1, 0, 1, modes[m]);
            runCase(126, 0, 2, 0, 0, 1, 1, modes[m]);
            runCase(37, 1, 0, 0, 0, 0, 0, modes[m]);
            runCase(37, 1, 0, 0, 1, 1, 1, modes[m]);
            runCase(5, 5, 4, 6, 1, 1, 0, modes[m]);
        end
        // Last connection was delta 0 with select 1: constant class, no illegal
        axiRead(ADDR_STATUS);
        check("status rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
        check("status", rd, 32'h0000_0002);
        final_report();
    end
endmodule
